//--- shared/spcc_defs.vh
// What this block does
// - Ten outputs, each muxing one of two clocks
// - Ten-bit serial word sets every output select
// - Load strobe moves shifted word into selects
// - Select zero routes clock one, one routes zero
// - Shifted data leaves on cascade output
`ifndef SPCC_DEFS_VH
`define SPCC_DEFS_VH

// ----------------------------------------------------------------
// Sizes and field positions
// ----------------------------------------------------------------
`define SPCC_NUM_OUT        10
`define SPCC_SEL_MSB        9
`define SPCC_CASCADE_BIT    9
`define SPCC_CNT_MSB        3
`define SPCC_SYNC_WIDTH     5

// Synchroniser lane positions
`define SPCC_LANE_SHIFTCLK  0
`define SPCC_LANE_DATA      1
`define SPCC_LANE_STROBE    2
`define SPCC_LANE_CLKZERO   3
`define SPCC_LANE_CLKONE    4

// ----------------------------------------------------------------
// Reset values and counter limit
// ----------------------------------------------------------------
`define SPCC_SEL_RESET      10'h000
`define SPCC_SHIFT_RESET    10'h000
`define SPCC_CNT_RESET      4'h0
`define SPCC_CNT_FULL       4'ha

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SPCC_REF_CLK_MHZ    200
`define SPCC_SHIFT_MAX_MHZ  20

`endif

//--- src/spcc_sync.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-flop synchroniser, one lane per pin
// ----------------------------------------------------------------
module spcc_sync #(
   parameter WIDTH = 5
) (
   // Clock and reset
   input  wire             ref_clk,
   input  wire             srst,
   // Asynchronous pins
   input  wire [WIDTH-1:0] asyncIn,
   // Synchronised levels
   output wire [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stageOne_reg;
   reg [WIDTH-1:0] stageTwo_reg;

   // First stage feeds only the second stage
   always @(posedge ref_clk) begin
      if (srst) begin
         stageOne_reg <= {WIDTH{1'b0}};
         stageTwo_reg <= {WIDTH{1'b0}};
      end else begin
         stageOne_reg <= asyncIn;
         stageTwo_reg <= stageOne_reg;
      end
   end

   assign syncOut = stageTwo_reg;

endmodule // spcc_sync

//--- src/spcc_crosspoint.v
`timescale 1ns/1ps
`include "spcc_defs.vh"
// ----------------------------------------------------------------
// Serially programmed two-by-ten clock crosspoint select logic
// ----------------------------------------------------------------
// All pins, the two input clocks among them, are sampled by ref_clk.
// The routed clocks are therefore a sampled image, good only for
// input clocks well below half the ref_clk rate.
module spcc_crosspoint (
   // Clock and reset
   input  wire                     ref_clk,
   input  wire                     srst,
   // Serial programming pins
   input  wire                     shiftClk,
   input  wire                     serialSelectIn,
   input  wire                     selectLatchStrobe,
   // Input clocks
   input  wire                     clockInputZero,
   input  wire                     clockInputOne,
   // Routed clocks and select state
   output wire [`SPCC_SEL_MSB:0]   routedClock,
   output wire [`SPCC_SEL_MSB:0]   outputSelect,
   // Cascade output
   output wire                     cascadeDataOut,
   // Status
   output wire [`SPCC_CNT_MSB:0]   shiftBitCount,
   output wire                     shiftRateError
);

   // ----------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------
   // Least spacing of shift edges, rounded up to whole ref_clk cycles
   localparam integer MIN_GAP_CYC =
      (`SPCC_REF_CLK_MHZ + `SPCC_SHIFT_MAX_MHZ - 1) / `SPCC_SHIFT_MAX_MHZ;
   localparam [`SPCC_CNT_MSB:0] MIN_GAP = MIN_GAP_CYC[`SPCC_CNT_MSB:0];
   localparam [`SPCC_CNT_MSB:0] CNT_ONE = 4'h1;

   // Edge tracker states
   localparam [1:0] ST_IDLE  = 2'b00;
   localparam [1:0] ST_SPACE = 2'b01;
   localparam [1:0] ST_READY = 2'b10;

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   wire [`SPCC_SYNC_WIDTH-1:0] pinSync;

   spcc_sync #(
      .WIDTH   (`SPCC_SYNC_WIDTH)
   ) uPinSync (
      .ref_clk (ref_clk),
      .srst    (srst),
      .asyncIn ({clockInputOne, clockInputZero, selectLatchStrobe,
                 serialSelectIn, shiftClk}),
      .syncOut (pinSync)
   );

   wire shiftClkSync = pinSync[`SPCC_LANE_SHIFTCLK];
   wire dataSync     = pinSync[`SPCC_LANE_DATA];
   wire strobeSync   = pinSync[`SPCC_LANE_STROBE];
   wire clkZeroSync  = pinSync[`SPCC_LANE_CLKZERO];
   wire clkOneSync   = pinSync[`SPCC_LANE_CLKONE];

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   reg  shiftClkPrev_reg;
   reg  strobePrev_reg;

   always @(posedge ref_clk) begin
      if (srst) begin
         shiftClkPrev_reg <= 1'b0;
         strobePrev_reg   <= 1'b0;
      end else begin
         shiftClkPrev_reg <= shiftClkSync;
         strobePrev_reg   <= strobeSync;
      end
   end

   // Data is sampled with the same latency as the clock, so it lines up
   wire shiftRise  = shiftClkSync & ~shiftClkPrev_reg;
   wire strobeRise = strobeSync & ~strobePrev_reg;

   // ----------------------------------------------------------------
   // Shift register and cascade output
   // ----------------------------------------------------------------
   reg  [`SPCC_SEL_MSB:0] shift_reg;
   reg  [`SPCC_SEL_MSB:0] shift_next;
   reg                    cascade_reg;

   always @* begin
      shift_next = shift_reg;
      if (shiftRise) begin
         shift_next = {shift_reg[`SPCC_SEL_MSB-1:0], dataSync};
      end
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         shift_reg   <= `SPCC_SHIFT_RESET;
         cascade_reg <= 1'b0;
      end else begin
         shift_reg   <= shift_next;
         cascade_reg <= shift_next[`SPCC_CASCADE_BIT];
      end
   end

   assign cascadeDataOut = cascade_reg;

   // ----------------------------------------------------------------
   // Latched selects
   // ----------------------------------------------------------------
   reg  [`SPCC_SEL_MSB:0] select_reg;
   reg  [`SPCC_SEL_MSB:0] select_next;

   always @* begin
      select_next = select_reg;
      // A load in the same cycle as a shift takes the word after the shift
      if (strobeRise) begin
         select_next = shift_next;
      end
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         select_reg <= `SPCC_SEL_RESET;
      end else begin
         select_reg <= select_next;
      end
   end

   assign outputSelect = select_reg;

   // ----------------------------------------------------------------
   // Output multiplexers
   // ----------------------------------------------------------------
   // Selects change freely against the input clocks, so a switch may
   // leave one short pulse on the output, as on the real crosspoint
   genvar chan;
   generate
      for (chan = 0; chan < `SPCC_NUM_OUT; chan = chan + 1) begin : gChan
         reg routed_reg;
         always @(posedge ref_clk) begin
            if (srst) begin
               routed_reg <= 1'b0;
            end else begin
               routed_reg <= select_reg[chan] ? clkZeroSync : clkOneSync;
            end
         end
         assign routedClock[chan] = routed_reg;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Shifted-bit counter
   // ----------------------------------------------------------------
   // Saturates at ten; longer words are legal when devices are chained
   reg  [`SPCC_CNT_MSB:0] count_reg;
   reg  [`SPCC_CNT_MSB:0] count_next;

   always @* begin
      count_next = count_reg;
      if (strobeRise) begin
         count_next = `SPCC_CNT_RESET;
      end else if (shiftRise && (count_reg != `SPCC_CNT_FULL)) begin
         count_next = count_reg + CNT_ONE;
      end
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         count_reg <= `SPCC_CNT_RESET;
      end else begin
         count_reg <= count_next;
      end
   end

   assign shiftBitCount = count_reg;

   // ----------------------------------------------------------------
   // Shift-rate watch
   // ----------------------------------------------------------------
   // The controller must keep shift edges apart; this only reports a
   // breach, since edges closer than the sampling rate may be lost
   reg  [1:0]             state_reg;
   reg  [1:0]             state_next;
   reg  [`SPCC_CNT_MSB:0] gap_reg;
   reg  [`SPCC_CNT_MSB:0] gap_next;
   reg                    rateErr_reg;
   reg                    rateErr_next;

   always @* begin
      state_next   = state_reg;
      gap_next     = gap_reg;
      rateErr_next = rateErr_reg;
      case (state_reg)
         ST_IDLE: begin
            if (shiftRise) begin
               state_next = ST_SPACE;
               gap_next   = CNT_ONE;
            end
         end
         ST_SPACE: begin
            if (shiftRise) begin
               rateErr_next = 1'b1;
               gap_next     = CNT_ONE;
            end else if (gap_reg == MIN_GAP - CNT_ONE) begin
               state_next = ST_READY;
            end else begin
               gap_next = gap_reg + CNT_ONE;
            end
         end
         ST_READY: begin
            if (shiftRise) begin
               state_next = ST_SPACE;
               gap_next   = CNT_ONE;
            end
         end
         default: begin
            state_next = ST_IDLE;
            gap_next   = `SPCC_CNT_RESET;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         state_reg   <= ST_IDLE;
         gap_reg     <= `SPCC_CNT_RESET;
         rateErr_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         gap_reg     <= gap_next;
         rateErr_reg <= rateErr_next;
      end
   end

   assign shiftRateError = rateErr_reg;

endmodule // spcc_crosspoint

//--- src/placeholder_none.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Intentionally empty
// ----------------------------------------------------------------

//--- verification/spcc_crosspoint_asserts.sv
`timescale 1ns/1ps
// --------------------
// Port checker
// --------------------
module spcc_crosspoint_asserts (
   // Clock and reset
   input wire       ref_clk,
   input wire       srst,
   // Pins
   input wire       shiftClk,
   input wire       serialSelectIn,
   input wire       selectLatchStrobe,
   input wire       clockInputZero,
   input wire       clockInputOne,
   // Results
   input wire [9:0] routedClock,
   input wire [9:0] outputSelect,
   input wire       cascadeDataOut,
   input wire [3:0] shiftBitCount,
   input wire       shiftRateError
);
   reg  [9:0] shadowReg;
   reg        shiftPrevReg;
   wire       shadowTop = shadowReg[9];
   // Shadow register sees shift edges two cycles before the design does
   always @(posedge ref_clk) begin
      shiftPrevReg <= shiftClk;
      if (srst)
         shadowReg <= 10'h000;
      else if (shiftClk && !shiftPrevReg)
         shadowReg <= {shadowReg[8:0], serialSelectIn};
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   chk_route_select: assert property (
      !$past(srst) && !$past(srst, 2) && !$past(srst, 3) |-> routedClock ==
      (($past(outputSelect) & {10{$past(clockInputZero, 3)}}) | (~$past(outputSelect) & {10{$past(clockInputOne, 3)}})))
      else $error("routed clock does not follow its select");
   chk_select_hold: assert property (
      !$past(srst) && $changed(outputSelect) |-> $past(selectLatchStrobe, 3) && !$past(selectLatchStrobe, 4))
      else $error("selects changed without a load");
   chk_load_word: assert property (
      $rose(selectLatchStrobe) |-> ##3 outputSelect == $past(shadowReg, 2))
      else $error("load did not take the shifted word");
   chk_load_clears: assert property (
      $rose(selectLatchStrobe) |-> ##3 shiftBitCount == 4'h0)
      else $error("load did not clear the bit count");
   chk_cascade_bit: assert property (
      !$past(srst) && !$past(srst, 2) |-> cascadeDataOut == $past(shadowTop, 2))
      else $error("cascade output is not the last stage");
   chk_rate_sticky: assert property (
      shiftRateError |=> shiftRateError)
      else $error("rate flag cleared without reset");
endmodule // spcc_crosspoint_asserts

bind spcc_crosspoint spcc_crosspoint_asserts spcc_crosspoint_asserts_inst (
   .ref_clk(ref_clk), .srst(srst), .shiftClk(shiftClk), .serialSelectIn(serialSelectIn),
   .selectLatchStrobe(selectLatchStrobe), .clockInputZero(clockInputZero), .clockInputOne(clockInputOne),
   .routedClock(routedClock), .outputSelect(outputSelect), .cascadeDataOut(cascadeDataOut),
   .shiftBitCount(shiftBitCount), .shiftRateError(shiftRateError));

//--- verification/spcc_serial_ctrl.sv
`timescale 1ns/1ps
// --------------------
// Serial controller
// --------------------
module spcc_serial_ctrl (
   // Clock
   input  wire ref_clk,
   // Serial pins
   output reg  shiftClk,
   output reg  serialSelectIn,
   output reg  selectLatchStrobe
);
   initial begin
      shiftClk = 1'b0;
      serialSelectIn = 1'b0;
      selectLatchStrobe = 1'b0;
   end
   // A half of 10 plus the bench's 5-cycle check gives 125 ns per bit;
   // a half of 3 is too fast on purpose. Data holds until the next bit.
   task shiftBit(input bit b, input int half);
      begin
         serialSelectIn = b;
         repeat (half) @(negedge ref_clk);
         shiftClk = 1'b1;
         repeat (half) @(negedge ref_clk);
         shiftClk = 1'b0;
      end
   endtask
   task latchWord;
      begin
         // Data pin returns to its idle low level before the load
         serialSelectIn = 1'b0;
         repeat (4) @(negedge ref_clk);
         selectLatchStrobe = 1'b1;
         repeat (4) @(negedge ref_clk);
         selectLatchStrobe = 1'b0;
         @(negedge ref_clk);
      end
   endtask
endmodule // spcc_serial_ctrl

//--- verification/tb_spcc_crosspoint.sv
`timescale 1ns/1ps
module tb_spcc_crosspoint;
   reg        ref_clk = 1'b0;
   reg        srst = 1'b1;
   reg        clockInputZero = 1'b0;
   reg        clockInputOne = 1'b0;
   wire       shiftClk, serialSelectIn, selectLatchStrobe, cascadeDataOut, shiftRateError;
   wire [9:0] routedClock, outputSelect;
   wire [3:0] shiftBitCount;
   reg  [9:0] shadow = 10'h000;
   reg  [9:0] loaded = 10'h000;
   int        mismatches = 0;
   int        cmp_count = 0;
   int        cycles = 0;
   reg  [2:0] zHist = 3'h0;
   reg  [2:0] oHist = 3'h0;
   // Input clocks toggle on falling edges, well below the sampling rate
   always #2.5 ref_clk = ~ref_clk;
   always #20 clockInputZero = ~clockInputZero;
   always #35 clockInputOne = ~clockInputOne;
   // Pin history: a routed output shows its input clock as sampled two edges before
   always @(posedge ref_clk) begin
      zHist <= {zHist[1:0], clockInputZero};
      oHist <= {oHist[1:0], clockInputOne};
   end
   spcc_serial_ctrl spcc_serial_ctrl_inst (.ref_clk(ref_clk), .shiftClk(shiftClk),
      .serialSelectIn(serialSelectIn), .selectLatchStrobe(selectLatchStrobe));
   spcc_crosspoint spcc_crosspoint_inst (.ref_clk(ref_clk), .srst(srst), .shiftClk(shiftClk),
      .serialSelectIn(serialSelectIn), .selectLatchStrobe(selectLatchStrobe), .clockInputZero(clockInputZero),
      .clockInputOne(clockInputOne), .routedClock(routedClock), .outputSelect(outputSelect),
      .cascadeDataOut(cascadeDataOut), .shiftBitCount(shiftBitCount), .shiftRateError(shiftRateError));
   task check(input string name, input [9:0] exp, input [9:0] got);
      begin
         cmp_count++;
         if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", cmp_count, mismatches);
         if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 8000) begin
         mismatches++;
         conclude;
      end
   end
   task pushBit(input bit b, input int n);
      begin
         spcc_serial_ctrl_inst.shiftBit(b, 10);
         shadow = {shadow[8:0], b};
         repeat (5) @(negedge ref_clk);
         check("cascade", {9'h000, shadow[9]}, {9'h000, cascadeDataOut});
         check("count", (n > 10) ? 10'h00a : n[9:0], {6'h00, shiftBitCount});
      end
   endtask
   task sendAndLoad(input [12:0] pat, input int nb);
      begin
         for (int i = nb - 1; i >= 0; i--) pushBit(pat[i], nb - i);
         check("select held", loaded, outputSelect);
         spcc_serial_ctrl_inst.latchWord;
         loaded = shadow;
         check("select", loaded, outputSelect);
         check("routed", (loaded & {10{zHist[2]}}) | (~loaded & {10{oHist[2]}}), routedClock);
         check("count cleared", 10'h000, {6'h00, shiftBitCount});
      end
   endtask
   task tIdle;
      begin
         check("idle select", 10'h000, outputSelect);
         check("idle routed", {10{oHist[2]}}, routedClock);
         check("idle count", 10'h000, {6'h00, shiftBitCount});
         check("idle flag", 10'h000, {9'h000, shiftRateError});
         check("idle cascade", 10'h000, {9'h000, cascadeDataOut});
      end
   endtask
   task tBackToBack;
      begin
         sendAndLoad(13'h03ff, 10);
         sendAndLoad(13'h0000, 10);
         sendAndLoad(13'h02a5, 10);
      end
   endtask
   task tOverfill;
      begin
         sendAndLoad(13'h1d5a, 13);
      end
   endtask
   task tRateAndReset;
      begin
         spcc_serial_ctrl_inst.shiftBit(1'b1, 3);
         spcc_serial_ctrl_inst.shiftBit(1'b0, 3);
         repeat (4) @(negedge ref_clk);
         check("rate flag", 10'h001, {9'h000, shiftRateError});
         check("count", 10'h002, {6'h00, shiftBitCount});
         srst = 1'b1;
         repeat (20) @(negedge ref_clk);
         srst = 1'b0;
         shadow = 10'h000;
         loaded = 10'h000;
         repeat (4) @(negedge ref_clk);
         tIdle;
         sendAndLoad(13'h0155, 10);
      end
   endtask
   initial begin
      repeat (20) @(negedge ref_clk);
      srst = 1'b0;
      repeat (4) @(negedge ref_clk);
      tIdle;
      tBackToBack;
      tOverfill;
      tRateAndReset;
      conclude;
   end
endmodule // tb_spcc_crosspoint
